// ==== verilog/tsflc_defines.svh ====
/*
 * Constants of the T1 superframe formatter and line coder: register
 * offsets, field positions, reset values, framing patterns and counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TSFLC_DEFINES_SVH
`define TSFLC_DEFINES_SVH

// ************************************************************
// Frame geometry
// ************************************************************
`define TSFLC_LAST_BIT 8'hc0
`define TSFLC_CH_LAST 3'h7
`define TSFLC_CH_B7 3'h6
`define TSFLC_SF_SHORT 5'h0c
`define TSFLC_SF_LONG 5'h18
`define TSFLC_TX_DELAY 8

// ************************************************************
// F-bit patterns, entry 0 in bit 0
// ************************************************************
`define TSFLC_FT_PAT 6'h15
`define TSFLC_FS_PAT 6'h1c
`define TSFLC_SEQ_PAT 6'h34

// ************************************************************
// Substitution word for a positive last mark, oldest in bit 7
// ************************************************************
`define TSFLC_B8_POS 8'h11
`define TSFLC_B8_NEG 8'h0a

// ************************************************************
// Register offsets, fields and reset values
// ************************************************************
`define TSFLC_REG_CTRL 4'h0
`define TSFLC_REG_CLEAR 4'h4
`define TSFLC_REG_STATUS 4'h8
`define TSFLC_REG_MASK 4'hc
`define TSFLC_CTRL_EXT 0
`define TSFLC_CTRL_STUFF 1
`define TSFLC_CTRL_B8ZS 2
`define TSFLC_CTRL_CRCSRC 3
`define TSFLC_CTRL_SIGLO 4
`define TSFLC_CTRL_SIGHI 5
`define TSFLC_CTRL_YEL 6
`define TSFLC_CTRL_RST 7'h00
`define TSFLC_CLEAR_RST 24'h00_0000
`define TSFLC_ST_CODE 0
`define TSFLC_ST_BPV 1
`define TSFLC_ST_SF 2
`define TSFLC_ST_RST 3'h0

`endif

// ==== verilog/tsflc_pkg.sv ====
/*
 * Types of the T1 superframe formatter and line coder.
 * Assumes nothing of its surroundings.
 */
package tsflc_pkg;
    typedef enum logic [1:0] {
        TSFLC_SIG_NONE,
        TSFLC_SIG_TWO,
        TSFLC_SIG_FOUR,
        TSFLC_SIG_SIXTEEN
    } tsflc_sig_mode_t;
endpackage

// ==== verilog/tsflc_tx_coder.sv ====
/*
 * Transmit bipolar coder: alternate mark inversion with optional
 * eight-zero substitution over an eight-bit look-ahead window.
 * Assumes one line bit per core_clk and an active-low reset released on core_clk.
 */
`timescale 1ns/1ps
`include "tsflc_defines.svh"
module tsflc_tx_coder (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic bit_in,
    input wire logic b8zs_en,
    output logic line_pos,
    output logic line_neg
);
    logic [7:0] m_q;
    logic [7:0] fp_q;
    logic [7:0] fn_q;
    logic last_pos_q;
    logic sub_pol_q;
    logic pulse_p;
    logic pulse_n;
    logic last_pos_d;
    logic sub_load;

    // Forced symbols carry their own polarity; raw marks alternate
    assign pulse_p = fp_q[7] | (m_q[7] & ~last_pos_q); // [RQ12]
    assign pulse_n = fn_q[7] | (m_q[7] & last_pos_q); // [RQ12]
    // Polarity survives frames and code words alike
    assign last_pos_d = pulse_p ? 1'b1 : (pulse_n ? 1'b0 : last_pos_q); // [RQ19]
    assign sub_load = b8zs_en && ({m_q[6:0], bit_in} == 8'h00) && (fp_q[6:0] == 7'h00) && (fn_q[6:0] == 7'h00);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            m_q <= 8'h00;
            fp_q <= 8'h00;
            fn_q <= 8'h00;
        end else if (sub_load) begin
            m_q <= 8'h00;
            fp_q <= last_pos_d ? `TSFLC_B8_POS : `TSFLC_B8_NEG; // [RQ14]
            fn_q <= last_pos_d ? `TSFLC_B8_NEG : `TSFLC_B8_POS; // [RQ14]
        end else begin
            m_q <= {m_q[6:0], bit_in};
            fp_q <= {fp_q[6:0], 1'b0};
            fn_q <= {fn_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_pos_q <= 1'b0;
            sub_pol_q <= 1'b0;
            line_pos <= 1'b0;
            line_neg <= 1'b0;
        end else begin
            last_pos_q <= last_pos_d;
            if (sub_load) begin
                sub_pol_q <= last_pos_d;
            end
            line_pos <= pulse_p;
            line_neg <= pulse_n;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_code_word;
        ##5 (line_pos == sub_pol_q && line_neg != sub_pol_q)
        ##1 (line_pos != sub_pol_q && line_neg == sub_pol_q)
        ##1 (!line_pos && !line_neg)
        ##1 (line_pos != sub_pol_q && line_neg == sub_pol_q)
        ##1 (line_pos == sub_pol_q && line_neg != sub_pol_q);
    endsequence
    a_b8zs_word: assert property (sub_load |-> s_code_word) else $error("bad substitution word"); // [RQ14]
    a_ami_alt: assert property (m_q[7] |=> line_pos != $past(last_pos_q) && line_neg == $past(last_pos_q))
        else $error("mark polarity did not alternate"); // [RQ12] [RQ19]
endmodule

// ==== verilog/tsflc_rx_decoder.sv ====
/*
 * Receive bipolar decoder: restores substitution words to zeros, flags
 * every word seen and reports other bipolar violations.
 * Assumes one line symbol per core_clk, never both rails at once.
 */
`timescale 1ns/1ps
`include "tsflc_defines.svh"
module tsflc_rx_decoder (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pos_in,
    input wire logic neg_in,
    input wire logic b8zs_en,
    output logic data_out,
    output logic bpv_out,
    output logic code_seen
);
    logic [7:0] p_q;
    logic [7:0] n_q;
    logic last_pos_q;
    logic last_pos_d;
    logic det;
    logic [7:0] p_sh;
    logic [7:0] n_sh;

    assign p_sh = {p_q[6:0], pos_in};
    assign n_sh = {n_q[6:0], neg_in};
    assign last_pos_d = p_q[7] ? 1'b1 : (n_q[7] ? 1'b0 : last_pos_q);
    // Detection runs whatever the enable says
    assign det = last_pos_d ? (p_sh == `TSFLC_B8_POS && n_sh == `TSFLC_B8_NEG)
                            : (p_sh == `TSFLC_B8_NEG && n_sh == `TSFLC_B8_POS);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            p_q <= 8'h00;
            n_q <= 8'h00;
        end else if (det && b8zs_en) begin
            // Wiping the word yields zeros and hides its violations
            p_q <= 8'h00; // [RQ16] [RQ15]
            n_q <= 8'h00;
        end else begin
            p_q <= p_sh;
            n_q <= n_sh;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_pos_q <= 1'b0;
            data_out <= 1'b0;
            bpv_out <= 1'b0;
            code_seen <= 1'b0;
        end else begin
            last_pos_q <= last_pos_d;
            data_out <= p_q[7] | n_q[7];
            bpv_out <= (p_q[7] & last_pos_q) | (n_q[7] & ~last_pos_q);
            code_seen <= det; // [RQ17]
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_zero_restore: assert property (det && b8zs_en |-> ##2 (!data_out) [*8])
        else $error("code word not restored to zeros"); // [RQ16]
    a_bpv_masked: assert property (det && b8zs_en |-> ##2 (!bpv_out) [*8])
        else $error("violation of code word reported"); // [RQ15]
    a_code_flag: assert property (det |=> code_seen) else $error("code word not flagged"); // [RQ17]
endmodule

// ==== verilog/tsflc_top.sv ====
/*
 * T1 superframe formatter and line coder: frame and superframe timing,
 * F-bit sequencing, robbed-bit signaling, bit-7 stuffing, AMI and B8ZS
 * coding, receive substitution monitor, registers and interrupt.
 * Assumes one line bit per core_clk, inputs synchronous to core_clk, and
 * a register master that holds strobes for one cycle, never both at once.
 */
`timescale 1ns/1ps
`include "tsflc_defines.svh"

// Contract
// RQ1: Frame is one F-bit then 24 channels of 8 bits.
// RQ2: Superframe is 12 frames in twelve_frame_mode, 24 in extended_frame_mode.
// RQ3: Channel bits go and come most significant first.
// RQ4: Short mode F-bits: odd frames 1,0,1,0,1,0; even frames 0,0,1,1,1,0.
// RQ5: Extended mode: pattern bits 0,0,1,0,1,1 every fourth frame, link odd, check bits.
// RQ6: Outside party presents link bits on tx_link_data_input.
// RQ7: Check bits generated internally, or sampled from serial input when selected.
// RQ8: Short mode puts A in frame 6, B in frame 12, channel LSB.
// RQ9: Extended mode puts A,B in frames 6,12 and C,D in 18,24.
// RQ10: Two, four and sixteen state signaling, with timing markers out.
// RQ11: Clear channels keep bit 8 as data in signaling frames.
// RQ12: Marks alternate polarity; zeros send no pulse.
// RQ13: Stuffing forces bit 7 of an all-zero channel to one.
// RQ14: Eight zeros become 000+-0-+ or 000-+0+- after last mark.
// RQ15: Enabled substitution hides its two violations from the error monitor.
// RQ16: Enabled substitution restores received code words to eight zeros.
// RQ17: Received code words are always flagged in status.
// RQ18: Frame 12 signaling framing bit may carry yellow alarm.
// RQ19: Last mark polarity tracked across frames and code words.
module tsflc_top
    import tsflc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic tx_serial_data_in,
    input wire logic tx_link_data_input,
    input wire logic [3:0] tx_sig_abcd,
    output logic tx_pos,
    output logic tx_neg,
    output logic tx_superframe_marker,
    output logic tx_signaling_frame_marker,
    output logic tx_signaling_select,
    input wire logic rx_pos_in,
    input wire logic rx_neg_in,
    output logic rx_data_out,
    output logic rx_bpv
);
    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [6:0] ctrl_q;
    logic [23:0] clear_q;
    logic [2:0] status_q;
    logic [2:0] status_d;
    logic [2:0] mask_q;
    logic [2:0] events;
    logic [2:0] clr_bits;
    logic ext_mode;
    logic stuff_en;
    logic b8zs_en;
    logic crc_ext;
    logic yel_en;
    tsflc_sig_mode_t sig_mode;
    logic rx_code_seen;
    logic sf_start;

    assign ext_mode = ctrl_q[`TSFLC_CTRL_EXT];
    assign stuff_en = ctrl_q[`TSFLC_CTRL_STUFF];
    assign b8zs_en = ctrl_q[`TSFLC_CTRL_B8ZS];
    assign crc_ext = ctrl_q[`TSFLC_CTRL_CRCSRC];
    assign yel_en = ctrl_q[`TSFLC_CTRL_YEL];
    assign sig_mode = tsflc_sig_mode_t'(ctrl_q[`TSFLC_CTRL_SIGHI:`TSFLC_CTRL_SIGLO]);

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= `TSFLC_CTRL_RST;
        end else if (reg_wr && reg_addr == `TSFLC_REG_CTRL) begin
            ctrl_q <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            clear_q <= `TSFLC_CLEAR_RST;
        end else if (reg_wr && reg_addr == `TSFLC_REG_CLEAR) begin
            clear_q <= reg_wdata[23:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= `TSFLC_ST_RST;
        end else if (reg_wr && reg_addr == `TSFLC_REG_MASK) begin
            mask_q <= reg_wdata[2:0];
        end
    end

    // Write one to clear; an event in the same cycle wins
    assign clr_bits = (reg_wr && reg_addr == `TSFLC_REG_STATUS) ? reg_wdata[2:0] : 3'h0;
    assign status_d = (status_q & ~clr_bits) | events;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            status_q <= `TSFLC_ST_RST;
            irq <= 1'b0;
        end else begin
            status_q <= status_d;
            irq <= |(status_q & mask_q);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `TSFLC_REG_CTRL: reg_rdata <= {25'h0, ctrl_q};
                `TSFLC_REG_CLEAR: reg_rdata <= {8'h0, clear_q};
                `TSFLC_REG_STATUS: reg_rdata <= {29'h0, status_q};
                `TSFLC_REG_MASK: reg_rdata <= {29'h0, mask_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // Frame and superframe timing
    // ************************************************************
    logic [7:0] bit_q;
    logic [4:0] frame_q;
    logic [4:0] sf_len;
    logic [7:0] bm1;
    logic [2:0] ch_pos;
    logic [4:0] ch_idx;
    logic [4:0] fm1;
    logic f_time;
    logic frame_end;

    assign f_time = (bit_q == 8'h00);
    assign frame_end = (bit_q == `TSFLC_LAST_BIT);
    assign sf_len = ext_mode ? `TSFLC_SF_LONG : `TSFLC_SF_SHORT;
    assign bm1 = bit_q - 8'h01;
    assign ch_pos = bm1[2:0];
    assign ch_idx = bm1[7:3];
    assign fm1 = frame_q - 5'h01;
    assign sf_start = f_time && frame_q == 5'h01;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bit_q <= 8'h00;
        end else if (frame_end) begin
            bit_q <= 8'h00; // [RQ1]
        end else begin
            bit_q <= bit_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            frame_q <= 5'h01;
        end else if (frame_end) begin
            // Greater-or-equal lets a mode switch mid-superframe recover
            frame_q <= (frame_q >= sf_len) ? 5'h01 : frame_q + 5'h01; // [RQ2]
        end
    end

    // ************************************************************
    // F-bit sequencing
    // ************************************************************
    logic [5:0] crc_q;
    logic [5:0] crc_last_q;
    logic f_bit;
    logic [2:0] idx_s;
    logic [2:0] idx_e;

    assign idx_s = fm1[3:1];
    assign idx_e = fm1[4:2];

    always_comb begin
        f_bit = tx_serial_data_in;
        if (!ext_mode) begin
            if (frame_q[0]) begin
                f_bit = 1'(`TSFLC_FT_PAT >> idx_s); // [RQ4]
            end else if (frame_q == `TSFLC_SF_SHORT && yel_en) begin
                f_bit = 1'b1; // [RQ18]
            end else begin
                f_bit = 1'(`TSFLC_FS_PAT >> idx_s); // [RQ4]
            end
        end else if (frame_q[1:0] == 2'h0) begin
            f_bit = 1'(`TSFLC_SEQ_PAT >> idx_e); // [RQ5]
        end else if (frame_q[0]) begin
            f_bit = tx_link_data_input; // [RQ5] [RQ6]
        end else if (!crc_ext) begin
            f_bit = crc_last_q[3'h5 - idx_e]; // [RQ7]
        end
    end

    // ************************************************************
    // Robbed-bit signaling and channel formatting
    // ************************************************************
    logic sig_frame;
    logic [1:0] sig_sel;
    logic sig_bit;
    logic sig_active;
    logic fmt_bit;

    always_comb begin
        sig_frame = 1'b0;
        sig_sel = 2'h0;
        case (frame_q)
            5'h06: sig_frame = 1'b1;
            5'h0c: begin
                sig_frame = 1'b1;
                sig_sel = 2'h1;
            end
            5'h12: begin
                sig_frame = ext_mode; // [RQ9]
                sig_sel = 2'h2;
            end
            5'h18: begin
                sig_frame = ext_mode;
                sig_sel = 2'h3;
            end
            default: sig_frame = 1'b0;
        endcase
    end

    always_comb begin
        case (sig_mode)
            TSFLC_SIG_TWO: sig_bit = tx_sig_abcd[3]; // [RQ10]
            TSFLC_SIG_FOUR: sig_bit = sig_sel[0] ? tx_sig_abcd[2] : tx_sig_abcd[3];
            TSFLC_SIG_SIXTEEN: sig_bit = tx_sig_abcd[2'h3 - sig_sel]; // [RQ8] [RQ9]
            default: sig_bit = 1'b0;
        endcase
    end

    // Bit 8 of non-clear channels only
    assign sig_active = sig_frame && sig_mode != TSFLC_SIG_NONE && !f_time
                        && ch_pos == `TSFLC_CH_LAST && !clear_q[ch_idx]; // [RQ11]
    assign fmt_bit = f_time ? f_bit : (sig_active ? sig_bit : tx_serial_data_in); // [RQ3]

    // ************************************************************
    // Eight-bit delay line with bit-7 stuffing
    // ************************************************************
    // The delay lets a whole channel be seen before its first bit leaves
    logic [7:0] dl_q;
    logic [7:0] dl_d;
    logic [7:0] ftag_q;
    logic [7:0] sftag_q;
    logic crc_in;
    logic [5:0] crc_step;

    always_comb begin
        dl_d = {dl_q[6:0], fmt_bit};
        if (stuff_en && !f_time && ch_pos == `TSFLC_CH_LAST && dl_d == 8'h00) begin
            dl_d[1] = 1'b1; // [RQ13]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dl_q <= 8'h00;
            ftag_q <= 8'h00;
            sftag_q <= 8'h00;
        end else begin
            dl_q <= dl_d;
            ftag_q <= {ftag_q[6:0], f_time};
            sftag_q <= {sftag_q[6:0], sf_start};
        end
    end

    // Check bits cover the sent stream with F-bits taken as ones
    assign crc_in = ftag_q[7] | dl_q[7];
    assign crc_step = sftag_q[7] ? {4'h0, {2{crc_in}}} : {crc_q[4:0], 1'b0} ^ {4'h0, {2{crc_q[5] ^ crc_in}}};

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            crc_q <= 6'h00;
            crc_last_q <= 6'h00;
        end else begin
            crc_q <= crc_step; // [RQ7]
            if (sftag_q[7]) begin
                crc_last_q <= crc_q;
            end
        end
    end

    // ************************************************************
    // Line coders and timing outputs
    // ************************************************************
    tsflc_tx_coder u_tx_coder (
        .core_clk(core_clk),
        .rst_n(rst_n_q),
        .bit_in(dl_q[7]),
        .b8zs_en(b8zs_en),
        .line_pos(tx_pos),
        .line_neg(tx_neg)
    );

    tsflc_rx_decoder u_rx_decoder (
        .core_clk(core_clk),
        .rst_n(rst_n_q),
        .pos_in(rx_pos_in),
        .neg_in(rx_neg_in),
        .b8zs_en(b8zs_en),
        .data_out(rx_data_out),
        .bpv_out(rx_bpv),
        .code_seen(rx_code_seen)
    );

    assign events = {sf_start, rx_bpv, rx_code_seen}; // [RQ17]

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_superframe_marker <= 1'b0;
            tx_signaling_frame_marker <= 1'b0;
            tx_signaling_select <= 1'b0;
        end else begin
            tx_superframe_marker <= frame_q == 5'h01;
            tx_signaling_frame_marker <= sig_frame; // [RQ10]
            tx_signaling_select <= sig_sel[0];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_q);

    sequence s_frame_end;
        frame_end ##1 (bit_q == 8'h00);
    endsequence
    a_frame_wrap: assert property (frame_end && frame_q < sf_len |-> s_frame_end ##0 frame_q == $past(frame_q) + 5'h01)
        else $error("frame length wrong"); // [RQ1]
    a_sf_wrap: assert property (frame_end && frame_q == sf_len |=> frame_q == 5'h01)
        else $error("superframe length wrong"); // [RQ2]
    a_data_msb: assert property (!f_time && ch_pos == 3'h0 |-> ##8 dl_q[7] == $past(tx_serial_data_in, 8))
        else $error("channel bit order wrong"); // [RQ3]
    a_fs_frame12: assert property (!ext_mode && f_time && frame_q == 5'h0c |-> f_bit == yel_en)
        else $error("frame 12 framing bit wrong"); // [RQ4] [RQ18]
    a_seq_bits: assert property (ext_mode && f_time && (frame_q == 5'h08 || frame_q == 5'h14)
        |-> f_bit == (frame_q == 5'h14)) else $error("pattern sequence bit wrong"); // [RQ5]
    a_fbit_path: assert property (f_time |-> ##8 dl_q[7] == $past(f_bit, 8))
        else $error("framing bit lost on way out"); // [RQ4] [RQ5]
    a_crc_ext: assert property (ext_mode && crc_ext && f_time && frame_q == 5'h02 |-> f_bit == tx_serial_data_in)
        else $error("external check bit not taken"); // [RQ7]
    a_stuff_b7: assert property (stuff_en && !f_time && ch_pos == `TSFLC_CH_LAST && {dl_q[6:0], fmt_bit} == 8'h00
        |=> dl_q[1]) else $error("zero channel not stuffed"); // [RQ13]
    a_clear_pass: assert property (!f_time && ch_pos == `TSFLC_CH_LAST && clear_q[ch_idx]
        |-> fmt_bit == tx_serial_data_in) else $error("clear channel bit 8 robbed"); // [RQ11]
    a_sig_bit: assert property (sig_active |-> ##8 dl_q[7] == $past(sig_bit, 8))
        else $error("signaling bit not inserted"); // [RQ8] [RQ9] [RQ10]
    a_code_irq: assert property (rx_code_seen && mask_q[0] && !(reg_wr && reg_addr == `TSFLC_REG_MASK)
        |-> ##2 irq) else $error("code word flag did not interrupt"); // [RQ17]
endmodule

// ==== tb/tsflc_line_model.sv ====
/* Line interface model: loops the transmit rails back to the receive rails.
 * Assumes one line symbol per core_clk on both rails. */
`timescale 1ns/1ps
module tsflc_line_model (
    input wire logic core_clk,
    input wire logic tx_pos,
    input wire logic tx_neg,
    output logic rx_pos,
    output logic rx_neg
);
    logic [5:0] dly_q = 6'h00;
    // Short cable delay; a space keeps both rails low, as on a real pair
    always_ff @(posedge core_clk) begin
        dly_q <= {dly_q[3:0], tx_pos, tx_neg};
    end
    assign rx_pos = dly_q[5];
    assign rx_neg = dly_q[4];
endmodule

// ==== tb/tsflc_top_bench.sv ====
/* Bench of the T1 formatter and line coder: framing, signaling, stuffing, coding.
 * Assumes the line model loops the transmit rails back to the receive rails. */
`timescale 1ns/1ps
`include "tsflc_defines.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tsflc_top_bench
    import tsflc_pkg::*;
;
    logic core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_link = 1'b0, b8 = 1'b0, last_pos = 1'b0;
    logic [3:0] reg_addr = 4'h0, abcd = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rd_q;
    logic irq, tx_pos, tx_neg, sf_mk, rx_pos, rx_neg, rx_data, rx_bpv, p, ser, sig_mk, sig_sel;
    logic [7:0] pv, nv;
    int failures = 0, comparisons = 0, cyc = 0, ones, bpvs, mk;
    int cnt [24];
    tsflc_top uut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .tx_serial_data_in(ser),
        .tx_link_data_input(tx_link), .tx_sig_abcd(abcd), .tx_pos(tx_pos), .tx_neg(tx_neg),
        .tx_superframe_marker(sf_mk), .tx_signaling_frame_marker(sig_mk), .tx_signaling_select(sig_sel),
        .rx_pos_in(rx_pos), .rx_neg_in(rx_neg), .rx_data_out(rx_data), .rx_bpv(rx_bpv));
    tsflc_line_model line (.core_clk(core_clk), .tx_pos(tx_pos), .tx_neg(tx_neg), .rx_pos(rx_pos),
        .rx_neg(rx_neg));
    initial forever #2.5 core_clk = ~core_clk;
    // ************************************************************
    // Monitors and helpers
    // ************************************************************
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 80000) begin
            failures++;
            finish_test();
        end
    end
    // Marks must alternate unless a substitution word is allowed
    always @(negedge core_clk) if (tx_pos | tx_neg) begin
        `CHK("one rail", 1'b0, tx_pos & tx_neg)
        if (!b8) `CHK("alternation", 1'b1, tx_pos ^ last_pos)
        last_pos = tx_pos;
    end
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask
    task automatic sync();
        @(negedge core_clk);
        while (sf_mk) @(negedge core_clk);
        while (!sf_mk) @(negedge core_clk);
    endtask
    // Windows start after the superframe marker so each holds one whole frame
    task automatic run_frames(input logic [31:0] ctrl, input logic [3:0] sig, input logic link,
            input logic [31:0] clr);
        @(posedge core_clk);
        abcd <= sig;
        tx_link <= link;
        ser <= link;
        wr(`TSFLC_REG_CLEAR, clr);
        wr(`TSFLC_REG_CTRL, ctrl);
        sync();
        repeat (15) @(negedge core_clk);
        mk = 0;
        for (int f = 0; f < 24; f++) begin
            cnt[f] = 0;
            repeat (193) begin
                @(negedge core_clk);
                cnt[f] += tx_pos | tx_neg;
                mk += sig_mk + 2 * sig_sel;
            end
        end
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        rd(`TSFLC_REG_CTRL);
        `CHK("ctrl reset", 32'h0000_0000, rd_q)
        rd(`TSFLC_REG_MASK);
        `CHK("mask reset", 32'h0000_0000, rd_q)
        wr(`TSFLC_REG_CTRL, 32'hFFFF_FFC8);
        rd(`TSFLC_REG_CTRL);
        `CHK("ctrl bits", 32'h0000_0048, rd_q)
        rd(4'h2);
        `CHK("unmapped", 32'h0000_0000, rd_q)
        $display("test regs done");
    endtask
    task automatic t_framing();
        run_frames(32'h0000_0000, 4'h0, 1'b0, 32'h0000_0000);
        for (int f = 0; f < 24; f++) `CHK("short f bit", int'((24'h3B_13B1 >> f) & 24'h00_0001), cnt[f])
        run_frames(32'h0000_0009, 4'h0, 1'b1, 32'h0000_0000);
        for (int f = 0; f < 24; f++) `CHK("ext f bit", 192 + int'((24'hFF_7F77 >> f) & 24'h00_0001), cnt[f])
        `CHK("sig markers", 1544, mk)
        $display("test framing done");
    endtask
    task automatic t_signaling();
        run_frames({26'h0, TSFLC_SIG_TWO, 4'h0}, 4'h8, 1'b0, 32'h0000_0001);
        `CHK("two state b frame", 23, cnt[11])
        `CHK("plain frame", 1, cnt[4])
        run_frames({26'h0, TSFLC_SIG_FOUR, 4'h0}, 4'h8, 1'b0, 32'h0000_0000);
        `CHK("four state a", 25, cnt[5])
        `CHK("four state b", 0, cnt[11])
        run_frames({26'h0, TSFLC_SIG_SIXTEEN, 4'h1}, 4'h5, 1'b0, 32'h0000_0000);
        `CHK("sixteen b", 25, cnt[11])
        `CHK("sixteen d", 25, cnt[23])
        run_frames(32'h0000_0002, 4'h0, 1'b0, 32'h0000_0000);
        `CHK("stuffed frame", 24, cnt[1])
        $display("test signaling done");
    endtask
    task automatic t_b8zs();
        b8 = 1'b1;
        wr(`TSFLC_REG_CTRL, 32'h0000_0004);
        sync();
        repeat (16) @(negedge core_clk);
        p = tx_pos;
        repeat (8) begin
            @(negedge core_clk);
            pv = {pv[6:0], tx_pos};
            nv = {nv[6:0], tx_neg};
        end
        `CHK("word pos", p ? 8'h11 : 8'h0a, pv)
        `CHK("word neg", p ? 8'h0a : 8'h11, nv)
        ones = 0;
        bpvs = 0;
        repeat (2316) begin
            @(negedge core_clk);
            ones += rx_data;
            bpvs += rx_bpv;
        end
        `CHK("rx ones", 6, ones)
        `CHK("rx bpv", 0, bpvs)
        rd(`TSFLC_REG_STATUS);
        `CHK("code seen", 1'b1, rd_q[0])
        `CHK("irq masked", 1'b0, irq)
        wr(`TSFLC_REG_MASK, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        #1 `CHK("irq set", 1'b1, irq)
        wr(`TSFLC_REG_CTRL, 32'h0000_0000);
        repeat (40) @(posedge core_clk);
        b8 = 1'b0;
        wr(`TSFLC_REG_STATUS, 32'h0000_0007);
        repeat (2) @(posedge core_clk);
        #1 `CHK("irq clear", 1'b0, irq)
        $display("test b8zs done");
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_regs();
        t_framing();
        t_signaling();
        t_b8zs();
        finish_test();
    end
endmodule
